/* cie_pkg.sv */
package cie_pkg;

	// ----------------------------------------------------------------
	// status flag positions and reset values
	// ----------------------------------------------------------------
	localparam int          FLAG_C      = 0;
	localparam int          FLAG_Z      = 1;
	localparam int          FLAG_N      = 2;
	localparam int          FLAG_V      = 3;
	localparam int          FLAG_S      = 4;
	localparam int          FLAG_H      = 5;
	localparam int          FLAG_T      = 6;
	localparam int          FLAG_I      = 7;
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET    = 16'h0000;
	localparam logic [7:0]  REG_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// fixed registers, steps and cycle counts
	// ----------------------------------------------------------------
	localparam logic [4:0]  REG_RESULT_LO = 5'h00;
	localparam logic [4:0]  REG_PTR_Z_LO  = 5'h1e;
	localparam logic [15:0] STEP_ONE      = 16'h0001;
	localparam logic [15:0] STEP_TWO      = 16'h0002;
	localparam logic [1:0]  CYC_1         = 2'h1;
	localparam logic [1:0]  CYC_2         = 2'h2;
	localparam logic [1:0]  CYC_3         = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM,
		OP_WORD_IMMEDIATE_ADD, OP_WORD_SUB_IMM, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
		OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_FMUL_UU, OP_FMUL_SS, OP_FRACTIONAL_MIXED_MULTIPLY,
		OP_JUMP_Z, OP_CALL_Z, OP_COMPARE_SKIP_EQUAL, OP_CMP, OP_CMP_CARRY, OP_CMP_IMM,
		OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET,
		OP_BRANCH_SET, OP_BRANCH_CLR, OP_IO_BIT_SET, OP_IO_BIT_CLR,
		OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
		OP_FLAG_SET, OP_FLAG_CLR, OP_MOVE, OP_REGISTER_PAIR_COPY, OP_LOAD_IMM,
		OP_LOAD_PTR, OP_STORE_PTR, OP_LOAD_DIRECT
	} cie_op_t;

	typedef enum logic [1:0] {PTR_PLAIN, PTR_POST_INC, PTR_PRE_DEC, PTR_DISP} cie_ptr_mode_t;

	typedef struct packed {
		cie_op_t       op;
		logic [4:0]    rd;
		logic [4:0]    rr;
		logic [7:0]    imm;
		logic [15:0]   addr;
		logic [4:0]    ptr_lo;
		cie_ptr_mode_t mode;
		logic          two_word;
		logic          next_two_word;
		logic [7:0]    io_value;
	} cie_instr_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        re;
		logic        we;
	} cie_dmem_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [2:0] bit_sel;
		logic       value;
		logic       we;
	} cie_io_bit_t;

	typedef struct packed {
		logic [15:0] ret_addr;
		logic        push;
	} cie_push_t;

endpackage

/* cie_exec_core.sv */
`timescale 1ns/1ps
// Function
// - add and add-with-carry write the sum in one cycle, flags Z C N V S H
// - word add/subtract immediate on a pair takes two cycles, flags Z C N V S
// - subtract with carry removes operand and carry in one cycle, flags Z C N V S H
// - and/or/xor take one cycle, touch only Z N V S, carry kept
// - multiplies place 16-bit product in result pair in two cycles, flags Z C
// - fractional multiplies shift the product left by one first
// - indirect jump loads pc from Z in two cycles; indirect call three, saving return
// - compare-skip-equal skips next on match; 1, 2 or 3 cycles
// - compares only set flags Z N V C H S, write no register, one cycle
// - skip-if-bit tests register or I/O bit, skips on match, 1 to 3 cycles
// - flag branches add offset plus one when taken; 1 or 2 cycles
// - signed branches decide on N xor V
// - I/O bit set/clear takes two cycles, changes only that bit, no flags
// - rotates through carry, one cycle, flags Z C N V S
// - bit-to-transfer copies a register bit into T, nothing else
// - transfer-to-bit copies T into a register bit, flags untouched
// - each status flag has a one-cycle set and clear
// - post-increment loads read at pointer then bump it, two cycles
// - pre-decrement stores drop the pointer then write there, two cycles
// - displacement accesses use pointer plus offset, pointer unchanged, two cycles
// - direct load reads the constant address into a register, two cycles
module cie_exec_core
	import cie_pkg::*;
#(
	parameter int NUM_REGS = 32
)(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// decoded instruction stream
	input  wire cie_instr_t  instr,
	input  wire logic        instr_valid,
	output logic             instr_ready,
	output logic [15:0]      pc,
	// data memory, read data valid while re is high
	output cie_dmem_t        dmem,
	input  wire logic [7:0]  dmem_rdata,
	// single-bit I/O writes and return-address push
	output cie_io_bit_t      io_bit,
	output cie_push_t        stack_push,
	// processor state
	output logic [7:0]       status_flags_register
);

	// ----------------------------------------------------------------
	// flag helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] arith_flags(input logic [7:0] a, input logic [7:0] b, input logic [7:0] r,
		input logic sub, input logic keepz, input logic [7:0] f);
		logic [7:0] o;
		logic       h;
		logic       v;
		logic       c;
		o = f;
		if (sub) begin
			h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
			v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
			c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		end else begin
			h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
			v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
			c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
		end
		o[FLAG_H] = h;
		o[FLAG_V] = v;
		o[FLAG_C] = c;
		o[FLAG_N] = r[7];
		o[FLAG_S] = r[7] ^ v;
		// a chained subtract only keeps zero if the earlier part was zero
		o[FLAG_Z] = (r == 8'h00) & (~keepz | f[FLAG_Z]);
		return o;
	endfunction

	function automatic logic [7:0] nzv_flags(input logic [7:0] r, input logic v, input logic [7:0] f);
		logic [7:0] o;
		o = f;
		o[FLAG_N] = r[7];
		o[FLAG_V] = v;
		o[FLAG_S] = r[7] ^ v;
		o[FLAG_Z] = (r == 8'h00);
		return o;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_EXEC = 2'b00, ST_WAIT = 2'b01, ST_LOAD = 2'b11} cie_state_t;

	cie_state_t  state;
	logic [7:0]  regs [NUM_REGS];
	logic [1:0]  wait_cnt;
	logic [4:0]  load_rd;

	// ----------------------------------------------------------------
	// operand selection
	// ----------------------------------------------------------------
	wire         accept   = instr_valid & instr_ready & (state == ST_EXEC);
	wire  [7:0]  opa      = regs[instr.rd];
	wire  [7:0]  opr      = regs[instr.rr];
	wire  [7:0]  flg      = status_flags_register;
	wire  [4:0]  pair_lo  = {instr.rd[4:1], 1'b0};
	wire  [15:0] pair_d   = {regs[{instr.rd[4:1], 1'b1}], regs[pair_lo]};
	wire  [15:0] ptr_val  = {regs[{instr.ptr_lo[4:1], 1'b1}], regs[{instr.ptr_lo[4:1], 1'b0}]};
	wire  [15:0] ptr_dec  = ptr_val - STEP_ONE;
	wire  [15:0] ptr_inc  = ptr_val + STEP_ONE;
	wire  [15:0] z_ptr    = {regs[REG_PTR_Z_LO + 5'h01], regs[REG_PTR_Z_LO]};
	wire  [15:0] pc_next  = pc + (instr.two_word ? STEP_TWO : STEP_ONE);
	wire  [15:0] skip_pc  = pc + STEP_ONE + (instr.next_two_word ? STEP_TWO : STEP_ONE);
	wire  [15:0] br_tgt   = pc + instr.addr + STEP_ONE;
	wire  [2:0]  bsel     = instr.imm[2:0];
	wire         reg_bit  = opr[bsel];
	wire         io_bitv  = instr.io_value[bsel];
	// signed test flag taken as N xor V
	wire         flag_bit = (bsel == 3'(FLAG_S)) ? (flg[FLAG_N] ^ flg[FLAG_V]) : flg[bsel];
	wire         br_taken = (instr.op == OP_BRANCH_SET) ? flag_bit : ~flag_bit;
	wire  [7:0]  sub_b    = (instr.op == OP_SUB_IMM || instr.op == OP_SUB_CARRY_IMM || instr.op == OP_CMP_IMM)
		? instr.imm : opr;
	wire         use_cin  = (instr.op == OP_SUB_CARRY || instr.op == OP_SUB_CARRY_IMM || instr.op == OP_CMP_CARRY);
	wire  [7:0]  sub_res  = opa - sub_b - {7'h00, use_cin & flg[FLAG_C]};
	wire  [7:0]  add_res  = opa + opr + {7'h00, (instr.op == OP_ADD_CARRY) & flg[FLAG_C]};
	wire  [15:0] wadd_res = pair_d + {8'h00, instr.imm};
	wire  [15:0] wsub_res = pair_d - {8'h00, instr.imm};
	wire         mul_sa   = instr.op inside {OP_MUL_SS, OP_MUL_SU, OP_FMUL_SS, OP_FRACTIONAL_MIXED_MULTIPLY};
	wire         mul_sb   = instr.op inside {OP_MUL_SS, OP_FMUL_SS};
	wire         mul_frac = instr.op inside {OP_FMUL_UU, OP_FMUL_SS, OP_FRACTIONAL_MIXED_MULTIPLY};
	wire  [17:0] mul_full = 18'($signed({mul_sa & opa[7], opa}) * $signed({mul_sb & opr[7], opr}));
	wire  [15:0] mul_res  = mul_frac ? {mul_full[14:0], 1'b0} : mul_full[15:0];
	wire  [7:0]  rot_res  = (instr.op == OP_ROTATE_LEFT) ? {opa[6:0], flg[FLAG_C]} : {flg[FLAG_C], opa[7:1]};
	wire         rot_c    = (instr.op == OP_ROTATE_LEFT) ? opa[7] : opa[0];

	// ----------------------------------------------------------------
	// execute decode
	// ----------------------------------------------------------------
	logic [7:0]  next_flags;
	logic [15:0] next_pc;
	logic [1:0]  next_cycles;
	logic        wa_en;
	logic [4:0]  wa_addr;
	logic [7:0]  wa_data;
	logic        ww_en;
	logic [4:0]  ww_addr;
	logic [15:0] ww_data;
	cie_dmem_t   next_dmem;
	cie_io_bit_t next_io;
	logic        next_push;
	logic        go_load;
	logic [7:0]  logic_res;
	logic [7:0]  tmp_flags;

	always_comb begin
		next_flags  = flg;
		next_pc     = pc_next;
		next_cycles = CYC_1;
		wa_en       = 1'b0;
		wa_addr     = instr.rd;
		wa_data     = 8'h00;
		ww_en       = 1'b0;
		ww_addr     = pair_lo;
		ww_data     = 16'h0000;
		next_dmem   = '{addr: 16'h0000, wdata: opr, re: 1'b0, we: 1'b0};
		next_io     = '{addr: instr.addr[4:0], bit_sel: bsel, value: 1'b0, we: 1'b0};
		next_push   = 1'b0;
		go_load     = 1'b0;
		logic_res   = 8'h00;
		tmp_flags   = flg;
		case (instr.op)
			OP_ADD, OP_ADD_CARRY: begin
				wa_en      = 1'b1;
				wa_data    = add_res;
				next_flags = arith_flags(opa, opr, add_res, 1'b0, 1'b0, flg);
			end
			OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM: begin
				wa_en      = 1'b1;
				wa_data    = sub_res;
				next_flags = arith_flags(opa, sub_b, sub_res, 1'b1, use_cin, flg);
			end
			OP_CMP, OP_CMP_CARRY, OP_CMP_IMM: begin
				next_flags = arith_flags(opa, sub_b, sub_res, 1'b1, use_cin, flg);
			end
			OP_WORD_IMMEDIATE_ADD, OP_WORD_SUB_IMM: begin
				ww_en       = 1'b1;
				next_cycles = CYC_2;
				ww_data     = (instr.op == OP_WORD_SUB_IMM) ? wsub_res : wadd_res;
				tmp_flags[FLAG_V] = (instr.op == OP_WORD_SUB_IMM) ? (pair_d[15] & ~wsub_res[15])
					: (~pair_d[15] & wadd_res[15]);
				tmp_flags[FLAG_C] = (instr.op == OP_WORD_SUB_IMM) ? (wsub_res[15] & ~pair_d[15])
					: (~wadd_res[15] & pair_d[15]);
				tmp_flags[FLAG_N] = ww_data[15];
				tmp_flags[FLAG_S] = ww_data[15] ^ tmp_flags[FLAG_V];
				tmp_flags[FLAG_Z] = (ww_data == 16'h0000);
				next_flags        = tmp_flags;
			end
			OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR: begin
				case (instr.op)
					OP_AND:     logic_res = opa & opr;
					OP_AND_IMM: logic_res = opa & instr.imm;
					OP_OR:      logic_res = opa | opr;
					OP_OR_IMM:  logic_res = opa | instr.imm;
					default:    logic_res = opa ^ opr;
				endcase
				wa_en      = 1'b1;
				wa_data    = logic_res;
				next_flags = nzv_flags(logic_res, 1'b0, flg);
			end
			// product into the fixed result pair; fractional shift
			OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_FMUL_UU, OP_FMUL_SS, OP_FRACTIONAL_MIXED_MULTIPLY: begin
				ww_en       = 1'b1;
				ww_addr     = REG_RESULT_LO;
				ww_data     = mul_res;
				next_cycles = CYC_2;
				next_flags[FLAG_C] = mul_full[15];
				next_flags[FLAG_Z] = (mul_res == 16'h0000);
			end
			// indirect jump and call through Z
			OP_JUMP_Z, OP_CALL_Z: begin
				next_pc     = z_ptr;
				next_push   = (instr.op == OP_CALL_Z);
				next_cycles = (instr.op == OP_CALL_Z) ? CYC_3 : CYC_2;
			end
			// compare and skip; skip on register or I/O bit
			OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET: begin
				if ((instr.op == OP_COMPARE_SKIP_EQUAL && opa == opr) ||
					(instr.op == OP_SKIP_REG_CLR && !reg_bit) || (instr.op == OP_SKIP_REG_SET && reg_bit) ||
					(instr.op == OP_SKIP_IO_CLR && !io_bitv) || (instr.op == OP_SKIP_IO_SET && io_bitv)) begin
					next_pc     = skip_pc;
					next_cycles = instr.next_two_word ? CYC_3 : CYC_2;
				end
			end
			// relative branch on a status bit
			OP_BRANCH_SET, OP_BRANCH_CLR: begin
				if (br_taken) begin
					next_pc     = br_tgt;
					next_cycles = CYC_2;
				end
			end
			// single I/O bit write, flags kept
			OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
				next_io.we    = 1'b1;
				next_io.value = (instr.op == OP_IO_BIT_SET);
				next_cycles   = CYC_2;
			end
			OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
				wa_en             = 1'b1;
				wa_data           = rot_res;
				tmp_flags[FLAG_C] = rot_c;
				next_flags        = nzv_flags(rot_res, rot_res[7] ^ rot_c, tmp_flags);
			end
			OP_BIT_TO_TRANSFER_FLAG: next_flags[FLAG_T] = reg_bit;
			OP_TRANSFER_FLAG_TO_BIT: begin
				wa_en          = 1'b1;
				wa_data        = opa;
				wa_data[bsel]  = flg[FLAG_T];
			end
			OP_FLAG_SET: next_flags[bsel] = 1'b1;
			OP_FLAG_CLR: next_flags[bsel] = 1'b0;
			// plain moves and pair copy, no flag change
			OP_MOVE: begin
				wa_en   = 1'b1;
				wa_data = opr;
			end
			OP_LOAD_IMM: begin
				wa_en   = 1'b1;
				wa_data = instr.imm;
			end
			OP_REGISTER_PAIR_COPY: begin
				ww_en   = 1'b1;
				ww_data = {regs[{instr.rr[4:1], 1'b1}], regs[{instr.rr[4:1], 1'b0}]};
			end
			// pointer loads and stores, flags kept
			OP_LOAD_PTR, OP_STORE_PTR: begin
				case (instr.mode)
					PTR_PRE_DEC: next_dmem.addr = ptr_dec;
					PTR_DISP:    next_dmem.addr = ptr_val + {8'h00, instr.imm};
					default:     next_dmem.addr = ptr_val;
				endcase
				ww_en       = (instr.mode == PTR_POST_INC) || (instr.mode == PTR_PRE_DEC);
				ww_addr     = {instr.ptr_lo[4:1], 1'b0};
				ww_data     = (instr.mode == PTR_PRE_DEC) ? ptr_dec : ptr_inc;
				next_dmem.re = (instr.op == OP_LOAD_PTR);
				next_dmem.we = (instr.op == OP_STORE_PTR);
				go_load     = (instr.op == OP_LOAD_PTR);
				next_cycles = CYC_2;
			end
			OP_LOAD_DIRECT: begin
				next_dmem.addr = instr.addr;
				next_dmem.re   = 1'b1;
				go_load        = 1'b1;
				next_cycles    = CYC_2;
			end
			default: ;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// load data lands on the second edge through the byte write port
	wire         a_en   = (state == ST_LOAD) | (accept & wa_en);
	wire  [4:0]  a_addr = (state == ST_LOAD) ? load_rd : wa_addr;
	wire  [7:0]  a_data = (state == ST_LOAD) ? dmem_rdata : wa_data;

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= REG_RESET;
			end
		end else begin
			if (a_en) begin
				regs[a_addr] <= a_data;
			end
			// pair port written last so a pointer update wins over a byte write
			if (accept && ww_en) begin
				regs[ww_addr]         <= ww_data[7:0];
				regs[ww_addr | 5'h01] <= ww_data[15:8];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state                 <= ST_EXEC;
			instr_ready           <= 1'b1;
			wait_cnt              <= 2'h0;
			load_rd               <= 5'h00;
			pc                    <= PC_RESET;
			status_flags_register <= FLAGS_RESET;
			dmem                  <= '0;
			io_bit                <= '0;
			stack_push            <= '0;
		end else begin
			dmem.re         <= 1'b0;
			dmem.we         <= 1'b0;
			io_bit.we       <= 1'b0;
			stack_push.push <= 1'b0;
			case (state)
				ST_EXEC: begin
					if (accept) begin
						pc                    <= next_pc;
						status_flags_register <= next_flags;
						dmem                  <= next_dmem;
						io_bit                <= next_io;
						stack_push            <= '{ret_addr: pc + STEP_ONE, push: next_push};
						load_rd               <= instr.rd;
						wait_cnt              <= next_cycles - CYC_2;
						instr_ready           <= (next_cycles == CYC_1);
						state                 <= go_load ? ST_LOAD : ((next_cycles == CYC_1) ? ST_EXEC : ST_WAIT);
					end
				end
				ST_WAIT: begin
					wait_cnt    <= wait_cnt - 2'h1;
					instr_ready <= (wait_cnt == 2'h0);
					state       <= (wait_cnt == 2'h0) ? ST_EXEC : ST_WAIT;
				end
				ST_LOAD: begin
					instr_ready <= 1'b1;
					state       <= ST_EXEC;
				end
				default: begin
					instr_ready <= 1'b1;
					state       <= ST_EXEC;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	wire         is_mul  = instr.op inside {OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_FMUL_UU, OP_FMUL_SS,
		OP_FRACTIONAL_MIXED_MULTIPLY};
	wire         is_word = instr.op inside {OP_WORD_IMMEDIATE_ADD, OP_WORD_SUB_IMM};
	wire         is_log  = instr.op inside {OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR};
	wire  [7:0]  no_t    = flg & ~(8'h01 << FLAG_T);
	wire  [4:0]  rd_q    = instr.rd;

	a_add_sum_write: assert property (accept && instr.op == OP_ADD
		|=> instr_ready && regs[$past(rd_q)] == $past(add_res))
		else $error("add result not written in one cycle");
	a_word_two_cycles: assert property (accept && is_word |=> !instr_ready ##1 instr_ready)
		else $error("word immediate op not two cycles");
	a_logic_keeps_c: assert property (accept && is_log |=> status_flags_register[FLAG_C] == $past(flg[FLAG_C]))
		else $error("logic op changed carry");
	a_mul_two_cycles: assert property (accept && is_mul
		|=> !instr_ready ##1 instr_ready && regs[REG_RESULT_LO] == $past(mul_res[7:0], 2)
		&& regs[REG_RESULT_LO | 5'h01] == $past(mul_res[15:8], 2))
		else $error("multiply timing or product wrong");
	a_jump_z_pc: assert property (accept && instr.op == OP_JUMP_Z |=> pc == $past(z_ptr) ##1 instr_ready)
		else $error("indirect jump wrong");
	a_skip_long_three: assert property (accept && instr.op == OP_COMPARE_SKIP_EQUAL && opa == opr
		&& instr.next_two_word |=> !instr_ready [*2] ##1 instr_ready)
		else $error("skip over two-word not three cycles");
	a_branch_taken_pc: assert property (accept && instr.op inside {OP_BRANCH_SET, OP_BRANCH_CLR} && br_taken
		|=> pc == $past(br_tgt) && !instr_ready)
		else $error("taken branch target or timing wrong");
	a_io_bit_only: assert property (accept && instr.op == OP_IO_BIT_SET
		|=> io_bit.we && io_bit.value && status_flags_register == $past(flg) ##1 instr_ready)
		else $error("I/O bit set wrong");
	a_t_flag_copy: assert property (accept && instr.op == OP_BIT_TO_TRANSFER_FLAG
		|=> status_flags_register[FLAG_T] == $past(reg_bit)
		&& (status_flags_register & ~(8'h01 << FLAG_T)) == $past(no_t))
		else $error("transfer flag copy wrong");
	a_load_post_inc: assert property (accept && instr.op == OP_LOAD_PTR && instr.mode == PTR_POST_INC
		|=> dmem.re && dmem.addr == $past(ptr_val) ##1 instr_ready)
		else $error("post-increment load wrong");
	a_store_pre_dec: assert property (accept && instr.op == OP_STORE_PTR && instr.mode == PTR_PRE_DEC
		|=> dmem.we && dmem.addr == $past(ptr_dec))
		else $error("pre-decrement store address wrong");

endmodule

/* cie_tb.sv */
`timescale 1ns/1ps
module testbench;
	import cie_pkg::*;
`define CK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
	// ----
	// stimulus state
	// ----
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        instr_valid = 1'b0;
	cie_instr_t  instr = '0;
	cie_instr_t  t = '0;
	logic        instr_ready;
	logic [15:0] pc, ep = 16'h0000, dp = 16'h0001, p, r;
	cie_dmem_t   dmem, dm;
	cie_io_bit_t io_bit, io;
	cie_push_t   stack_push, ps;
	logic [7:0]  status_flags_register, f1, ef = 8'h00, m = 8'hff, a, b, v, dmem_rdata;
	int          n_errors = 0;
	int          comparisons = 0;
	cie_op_t     op;
	cie_op_t     ao[14] = '{OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM, OP_AND,
		OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_CMP, OP_CMP_CARRY, OP_CMP_IMM};
	cie_op_t     mu[6] = '{OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_FMUL_UU, OP_FMUL_SS, OP_FRACTIONAL_MIXED_MULTIPLY};
	cie_op_t     sk[5] = '{OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET, OP_COMPARE_SKIP_EQUAL};

	cie_exec_core cie_exec_core_i (.mclk(mclk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .pc(pc), .dmem(dmem), .dmem_rdata(dmem_rdata), .io_bit(io_bit),
		.stack_push(stack_push), .status_flags_register(status_flags_register));

	always #2.5 mclk = ~mclk;
	// memory answers with a pattern tied to the address, so a wrong address shows in the data
	function automatic logic [7:0] md(logic [15:0] ad);
		return ad[7:0] ^ ad[15:8] ^ 8'h3c;
	endfunction
	assign dmem_rdata = md(dmem.addr);

	function automatic logic [15:0] alu(cie_op_t o, logic [7:0] a, logic [7:0] b, logic [7:0] f);
		logic [8:0] s;
		logic       sb, cy, lg;
		sb = o inside {OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM, OP_CMP, OP_CMP_CARRY, OP_CMP_IMM};
		cy = o inside {OP_ADD_CARRY, OP_SUB_CARRY, OP_SUB_CARRY_IMM, OP_CMP_CARRY};
		lg = o inside {OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR};
		s = sb ? {1'b0, a} - {1'b0, b} - 9'(cy & f[FLAG_C]) : {1'b0, a} + {1'b0, b} + 9'(cy & f[FLAG_C]);
		if (o inside {OP_AND, OP_AND_IMM}) s = {1'b0, a & b};
		if (o inside {OP_OR, OP_OR_IMM}) s = {1'b0, a | b};
		if (o == OP_XOR) s = {1'b0, a ^ b};
		// carry-chained subtracts only keep zero, never set it
		f[FLAG_Z] = s[7:0] == 8'h00 && (!(sb && cy) || f[FLAG_Z]);
		f[FLAG_N] = s[7];
		f[FLAG_V] = !lg && (sb ? (a[7] ^ b[7]) & (a[7] ^ s[7]) : ~(a[7] ^ b[7]) & (a[7] ^ s[7]));
		if (!lg) f[FLAG_C] = s[8];
		if (!lg && sb) f[FLAG_H] = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
		if (!lg && !sb) f[FLAG_H] = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
		return {s[7:0], f};
	endfunction

	function automatic logic [16:0] mul(cie_op_t o, logic [7:0] a, logic [7:0] b);
		int          x1, x2;
		logic [15:0] q;
		x1 = o inside {OP_MUL_UU, OP_FMUL_UU} ? int'(a) : int'($signed(a));
		x2 = o inside {OP_MUL_SS, OP_FMUL_SS} ? int'($signed(b)) : int'(b);
		q = 16'(x1 * x2);
		return {q[15], o inside {OP_FMUL_UU, OP_FMUL_SS, OP_FRACTIONAL_MIXED_MULTIPLY} ? q << 1 : q};
	endfunction

	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one instruction: checks cycle count, next pc and every flag selected by m against the model
	task automatic x(cie_op_t o, logic [4:0] d, logic [4:0] s, logic [7:0] k, int n);
		int c;
		t.op = o;
		t.rd = d;
		t.rr = s;
		t.imm = k;
		ep = ep + dp;
		@(posedge mclk);
		instr <= t;
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
		dm = dmem;
		io = io_bit;
		ps = stack_push;
		f1 = status_flags_register;
		c = 1;
		while (instr_ready !== 1'b1 && c < 9) begin
			@(negedge mclk);
			c++;
		end
		`CK(c, n)
		`CK(pc, ep)
		`CK(f1 & m, ef & m)
		if (c > 8) report_and_stop();
		t = '0;
		dp = 16'h0001;
		m = 8'hff;
	endtask

	task automatic fl(int i, logic s);
		ef[i] = s;
		x(s ? OP_FLAG_SET : OP_FLAG_CLR, 0, 0, 8'(i), 1);
	endtask

	task automatic ld(logic [4:0] d, logic [7:0] k);
		x(OP_LOAD_IMM, d, 0, k, 1);
	endtask

	// a register is seen only through a store of it
	task automatic st(logic [4:0] s, logic [7:0] e);
		t.ptr_lo = REG_PTR_Z_LO;
		x(OP_STORE_PTR, s, s, 0, 2);
		`CK({dm.we, dm.wdata}, {1'b1, e})
	endtask

	task automatic mo(cie_op_t o, logic [4:0] pl, cie_ptr_mode_t pm, logic [7:0] q, logic [15:0] ea);
		t.ptr_lo = pl;
		t.mode = pm;
		t.addr = ea;
		x(o, 16, 16, q, 2);
		`CK({dm.addr, o == OP_STORE_PTR ? dm.we : dm.re}, {ea, 1'b1})
	endtask

	initial begin
		void'($urandom(59563));
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		for (int i = 0; i < 16; i++)
			fl(i % 8, i < 8);
		for (int j = 0; j < 70; j++) begin
			op = ao[j % 14];
			a = (j < 14) ? 8'h80 : (j < 28) ? 8'h0f : 8'($urandom);
			b = (j < 14) ? 8'h80 : (j < 28) ? 8'h01 : 8'($urandom);
			ld(16, a);
			ld(17, b);
			fl(FLAG_C, 1'($urandom_range(1, 0)));
			fl(FLAG_Z, 1'($urandom_range(1, 0)));
			p = alu(op, a, b, ef);
			ef = p[7:0];
			m = 8'hef;
			x(op, 16, 17, b, 1);
			fl(FLAG_S, 1'b0);
			st(16, op inside {OP_CMP, OP_CMP_CARRY, OP_CMP_IMM} ? a : p[15:8]);
		end
		for (int j = 0; j < 24; j++) begin
			op = mu[j % 6];
			a = (j < 6) ? 8'h80 : 8'($urandom);
			b = (j < 6) ? 8'h80 : 8'($urandom);
			ld(16, a);
			ld(17, b);
			{ef[FLAG_C], p} = mul(op, a, b);
			ef[FLAG_Z] = p == 16'h0000;
			x(op, 16, 17, 0, 2);
			st(0, p[7:0]);
			st(1, p[15:8]);
		end
		for (int j = 0; j < 8; j++) begin
			op = j[0] ? OP_WORD_SUB_IMM : OP_WORD_IMMEDIATE_ADD;
			r = (j < 2) ? (j[0] ? 16'h8000 : 16'h7fff) : 16'($urandom);
			b = (j < 2) ? 8'h01 : 8'($urandom_range(63, 0));
			ld(24, r[7:0]);
			ld(25, r[15:8]);
			{ef[FLAG_C], p} = j[0] ? {1'b0, r} - 17'(b) : {1'b0, r} + 17'(b);
			ef[FLAG_Z] = p == 16'h0000;
			ef[FLAG_N] = p[15];
			ef[FLAG_V] = j[0] ? r[15] & ~p[15] : ~r[15] & p[15];
			ef[FLAG_S] = p[15] ^ ef[FLAG_V];
			x(op, 24, 24, b, 2);
			st(24, p[7:0]);
			st(25, p[15:8]);
		end
		for (int j = 0; j < 8; j++) begin
			a = 8'($urandom);
			b = 8'($urandom);
			ld(16, a);
			ld(17, b);
			fl(FLAG_C, j[0]);
			v = j[1] ? {j[0], a[7:1]} : {a[6:0], j[0]};
			ef[FLAG_C] = j[1] ? a[0] : a[7];
			ef[FLAG_Z] = v == 8'h00;
			ef[FLAG_N] = v[7];
			ef[FLAG_V] = v[7] ^ ef[FLAG_C];
			m = 8'hef;
			x(j[1] ? OP_ROTATE_RIGHT : OP_ROTATE_LEFT, 16, 16, 0, 1);
			fl(FLAG_S, 1'b0);
			ef[FLAG_T] = b[j];
			x(OP_BIT_TO_TRANSFER_FLAG, 17, 17, 8'(j), 1);
			v[7 - j] = b[j];
			x(OP_TRANSFER_FLAG_TO_BIT, 16, 16, 8'(7 - j), 1);
			x(OP_REGISTER_PAIR_COPY, 2, 16, 0, 1);
			x(OP_MOVE, 4, 17, 0, 1);
			st(2, v);
			st(3, b);
			st(4, b);
		end
		for (int j = 0; j < 32; j++) begin
			v = 8'($urandom);
			for (int i = 0; i < 8; i++)
				fl(i, v[i]);
			b[0] = ((j % 8 == FLAG_S) ? v[FLAG_N] ^ v[FLAG_V] : v[j % 8]) ^ j[4];
			t.addr = 16'($urandom_range(40, 0)) - 16'h0014;
			dp = b[0] ? t.addr + 16'h0001 : 16'h0001;
			x(j[4] ? OP_BRANCH_CLR : OP_BRANCH_SET, 0, 0, 8'(j % 8), b[0] ? 2 : 1);
		end
		for (int j = 0; j < 20; j++) begin
			op = sk[j % 5];
			a = 8'($urandom);
			b = 8'($urandom_range(7, 0));
			ld(16, a);
			ld(17, j[1] ? a : ~a);
			t.io_value = a;
			t.addr = 16'($urandom_range(31, 0));
			t.next_two_word = j[2];
			v[0] = (op == OP_COMPARE_SKIP_EQUAL) ? j[1] : a[b[2:0]] == (op inside {OP_SKIP_REG_SET, OP_SKIP_IO_SET});
			dp = v[0] ? (j[2] ? 16'h0003 : 16'h0002) : 16'h0001;
			x(op, 16, (op == OP_COMPARE_SKIP_EQUAL) ? 5'h11 : 5'h10, b, int'(dp));
		end
		for (int j = 0; j < 4; j++) begin
			a = 8'($urandom_range(31, 0));
			b = 8'($urandom_range(7, 0));
			t.addr = {11'h000, a[4:0]};
			x(j[0] ? OP_IO_BIT_CLR : OP_IO_BIT_SET, 0, 0, b, 2);
			`CK({io.we, io.addr, io.bit_sel, io.value}, {1'b1, a[4:0], b[2:0], ~j[0]})
			a = 8'($urandom);
			b = 8'($urandom);
			ld(30, a);
			ld(31, b);
			r = ep + 16'h0001;
			dp = {b, a} - ep;
			x(j[1] ? OP_CALL_Z : OP_JUMP_Z, 0, 0, 0, j[1] ? 3 : 2);
			`CK({ps.push, ps.ret_addr}, {j[1], j[1] ? r : ps.ret_addr})
		end
		ld(26, 8'hff);
		ld(27, 8'h12);
		ld(28, 8'h00);
		ld(29, 8'h20);
		mo(OP_LOAD_PTR, 26, PTR_POST_INC, 0, 16'h12ff);
		st(16, md(16'h12ff));
		mo(OP_LOAD_PTR, 26, PTR_PLAIN, 0, 16'h1300);
		mo(OP_STORE_PTR, 28, PTR_PRE_DEC, 0, 16'h1fff);
		`CK(dm.wdata, md(16'h1300))
		mo(OP_LOAD_PTR, 28, PTR_DISP, 8'h3f, 16'h203e);
		mo(OP_STORE_PTR, 28, PTR_DISP, 8'h3f, 16'h203e);
		mo(OP_LOAD_PTR, 28, PTR_PRE_DEC, 0, 16'h1ffe);
		mo(OP_STORE_PTR, 26, PTR_POST_INC, 0, 16'h1300);
		mo(OP_STORE_PTR, 26, PTR_PLAIN, 0, 16'h1301);
		// the direct load carries its address in a second word, so pc moves by two
		t.two_word = 1'b1;
		dp = 16'h0002;
		mo(OP_LOAD_DIRECT, 0, PTR_PLAIN, 0, 16'hbeef);
		st(16, md(16'hbeef));
		report_and_stop();
	end
endmodule
